// *** hcdf_pkg.sv ***
/*
 package for the host channel and diagnostic frame block: byte codes, flag layout,
 channel limits, timing and conversion constants.
 assumes a single 10 MHz pclk shared by host end and device end.
*/
package hcdf_pkg;
    localparam logic [7:0] HCDF_SW_LEAD = 8'h00;
    localparam logic [7:0] HCDF_SW_ADDR = 8'h10;
    localparam logic [7:0] HCDF_SW_BCAST = 8'h11;
    localparam logic [7:0] HCDF_CH_MIN = 8'h01;
    localparam logic [7:0] HCDF_CH_MAX = 8'h06;
    localparam logic [7:0] HCDF_CH_MAX_25K = 8'h03;
    localparam logic [7:0] HCDF_DIAG_FLAG = 8'h08;
    localparam logic [7:0] HCDF_PAY_MIN = 8'h01;
    localparam int HCDF_MAX_RPT = 8;
    localparam int HCDF_FLAG_BCAST = 0;
    localparam int HCDF_FLAG_ECHO = 1;
    localparam int HCDF_FLAG_ACK = 2;
    localparam int HCDF_FLAG_DIAG = 3;
    localparam logic [2:0] HCDF_RST_CHANNEL = 3'h1;
    localparam int HCDF_CLK_HZ = 10000000;
    localparam int HCDF_SW_WAIT_US = 2000;
    localparam int HCDF_SW_WAIT_CYC = (HCDF_SW_WAIT_US * (HCDF_CLK_HZ / 1000000));
    localparam int HCDF_RSSI_OFS_DBM = 130;
    localparam int HCDF_BATT_DIV_X10 = 211;
    localparam logic [1:0] HCDF_REPLY_LEN = 2'h3;
    // apb offsets of the host end registers
    localparam logic [11:0] HCDF_A_CTRL = 12'h000;
    localparam logic [11:0] HCDF_A_TX = 12'h004;
    localparam logic [11:0] HCDF_A_STAT = 12'h008;
    localparam logic [11:0] HCDF_A_RX = 12'h00c;
    localparam logic [11:0] HCDF_A_CONV = 12'h010;
endpackage

// *** hcdf_if.sv ***
/*
 byte link between host equipment and the device frame parser.
 assumes both ends run on the same pclk; host bytes move on valid with ready, reply bytes on valid alone.
*/
`timescale 1ns/10ps
interface hcdf_if;
    logic [7:0] h2d_data;
    logic h2d_valid;
    logic h2d_ready;
    logic [7:0] d2h_data;
    logic d2h_valid;
    modport host (output h2d_data, output h2d_valid, input h2d_ready,
        input d2h_data, input d2h_valid);
    modport device (input h2d_data, input h2d_valid, output h2d_ready,
        output d2h_data, output d2h_valid);
endinterface

// *** hcdf_device.sv ***
/*
 device end: parses host bytes for channel switch and diagnostic frames, keeps the
 channel, and returns remote readings with the local rssi appended.
 assumes host bytes arrive on the link interface and radio readings on a strobe.
*/
`timescale 1ns/10ps
module hcdf_device (
    input wire logic pclk,
    input wire logic presetn,
    hcdf_if.device link,
    input wire logic host_supplied_addressing,
    input wire logic adaptive_freq_agility,
    input wire logic spacing_25k,
    input wire logic [7:0] system_code,
    input wire logic remote_valid,
    input wire logic [7:0] supply_level_reading,
    input wire logic [7:0] remote_rssi,
    input wire logic [7:0] local_rssi,
    output logic [2:0] channel,
    output logic channel_strobe,
    output logic diag_request,
    output logic [7:0] diag_target,
    output logic [7:0] diag_payload,
    output logic frame_error
);
    import hcdf_pkg::*;
    typedef enum {HCDF_IDLE, HCDF_SW_KIND, HCDF_SW_CH, HCDF_DG_FLAG, HCDF_DG_CNT,
        HCDF_DG_ROUTE, HCDF_DG_PAY} hcdf_st_t;
    typedef struct packed {
        hcdf_st_t st;
        logic bcast;
        logic [3:0] left;
        logic [7:0] target;
        logic [2:0] channel;
        logic channel_strobe;
        logic diag_request;
        logic [7:0] diag_target;
        logic [7:0] diag_payload;
        logic frame_error;
        logic [1:0] reply_cnt;
        logic [7:0] r_batt;
        logic [7:0] r_rssi;
        logic [7:0] r_local;
        logic [7:0] d2h_data;
        logic d2h_valid;
    } hcdf_dev_t;
    hcdf_dev_t s, next_s;
    logic [7:0] b;
    logic [7:0] ch_top;

    always_comb begin
        next_s = s;
        b = link.h2d_data;
        ch_top = spacing_25k ? HCDF_CH_MAX_25K : HCDF_CH_MAX;
        next_s.channel_strobe = 1'b0;
        next_s.diag_request = 1'b0;
        next_s.frame_error = 1'b0;
        next_s.d2h_valid = 1'b0;
        // ========================================
        // frame parser
        if (link.h2d_valid) begin
            case (s.st)
                HCDF_IDLE: begin
                    if (b == HCDF_SW_LEAD && host_supplied_addressing
                            && !adaptive_freq_agility) begin
                        next_s.st = HCDF_SW_KIND;
                    end else if (b == system_code && host_supplied_addressing) begin
                        next_s.st = HCDF_DG_FLAG;
                    end
                end
                HCDF_SW_KIND: begin
                    if (b == HCDF_SW_ADDR || b == HCDF_SW_BCAST) begin
                        next_s.bcast = (b == HCDF_SW_BCAST);
                        next_s.st = HCDF_SW_CH;
                    end else begin
                        next_s.frame_error = 1'b1;
                        next_s.st = HCDF_IDLE;
                    end
                end
                HCDF_SW_CH: begin
                    next_s.st = HCDF_IDLE;
                    if (b >= HCDF_CH_MIN && b <= ch_top) begin
                        next_s.channel = b[2:0];
                        next_s.channel_strobe = 1'b1;
                    end else begin
                        next_s.frame_error = 1'b1;
                    end
                end
                HCDF_DG_FLAG: begin
                    // every other flag bit must be zero and the diag bit set
                    if (b == HCDF_DIAG_FLAG && b[HCDF_FLAG_DIAG]) begin
                        next_s.st = HCDF_DG_CNT;
                    end else begin
                        next_s.frame_error = 1'b1;
                        next_s.st = HCDF_IDLE;
                    end
                end
                HCDF_DG_CNT: begin
                    // count covers repeaters plus target
                    if (b >= 8'h01 && b <= 8'(HCDF_MAX_RPT + 1)) begin
                        next_s.left = b[3:0];
                        next_s.st = HCDF_DG_ROUTE;
                    end else begin
                        next_s.frame_error = 1'b1;
                        next_s.st = HCDF_IDLE;
                    end
                end
                HCDF_DG_ROUTE: begin
                    next_s.target = b;
                    next_s.left = s.left - 4'h1;
                    if (s.left == 4'h1) begin
                        next_s.st = HCDF_DG_PAY;
                    end
                end
                HCDF_DG_PAY: begin
                    next_s.st = HCDF_IDLE;
                    if (b >= HCDF_PAY_MIN) begin
                        next_s.diag_request = 1'b1;
                        next_s.diag_target = s.target;
                        next_s.diag_payload = b;
                    end else begin
                        next_s.frame_error = 1'b1;
                    end
                end
                default: next_s.st = HCDF_IDLE;
            endcase
        end
        // ========================================
        // reply path: battery, remote rssi, then local rssi
        if (remote_valid && s.reply_cnt == 2'h0) begin
            next_s.r_batt = supply_level_reading;
            next_s.r_rssi = remote_rssi;
            next_s.r_local = local_rssi;
            next_s.reply_cnt = HCDF_REPLY_LEN;
        end else if (s.reply_cnt != 2'h0) begin
            next_s.d2h_valid = 1'b1;
            next_s.reply_cnt = s.reply_cnt - 2'h1;
            case (s.reply_cnt)
                2'h3: next_s.d2h_data = s.r_batt;
                2'h2: next_s.d2h_data = s.r_rssi;
                default: next_s.d2h_data = s.r_local;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= HCDF_IDLE;
            s.channel <= HCDF_RST_CHANNEL;
        end else begin
            s <= next_s;
        end
    end

    // parser accepts a byte every cycle
    assign link.h2d_ready = 1'b1;
    assign link.d2h_data = s.d2h_data;
    assign link.d2h_valid = s.d2h_valid;
    assign channel = s.channel;
    assign channel_strobe = s.channel_strobe;
    assign diag_request = s.diag_request;
    assign diag_target = s.diag_target;
    assign diag_payload = s.diag_payload;
    assign frame_error = s.frame_error;
endmodule

// *** hcdf_host.sv ***
/*
 host end: apb slave that sends bytes, enforces the post switch wait, and
 collects the three reply bytes with converted readings.
 assumes the device end on the same pclk through the link interface.
*/
`timescale 1ns/10ps
module hcdf_host #(
    parameter int SW_WAIT_CYC = hcdf_pkg::HCDF_SW_WAIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    hcdf_if.host link
);
    import hcdf_pkg::*;
    typedef struct packed {
        logic [7:0] tx;
        logic tx_valid;
        logic sw_seen;
        logic [15:0] wait_cnt;
        logic [1:0] rx_idx;
        logic [23:0] rx;
        logic rx_done;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } hcdf_host_t;
    hcdf_host_t s, next_s;
    logic wr, rd;
    logic [7:0] rssi_r, rssi_l;
    logic [10:0] batt_cv;

    always_comb begin
        next_s = s;
        wr = psel && penable && pwrite && !s.pready;
        rd = psel && penable && !pwrite && !s.pready;
        next_s.pready = psel && penable && !s.pready;
        next_s.pslverr = 1'b0;
        // dBm magnitude: 130 - raw/2, always positive for 8-bit raw
        rssi_r = 8'(HCDF_RSSI_OFS_DBM) - {1'b0, s.rx[15:9]};
        rssi_l = 8'(HCDF_RSSI_OFS_DBM) - {1'b0, s.rx[7:1]};
        // battery in centivolts: raw*1000/211
        // full scale raw reaches 1208, so the field needs 11 bits
        batt_cv = 11'((32'(s.rx[23:16]) * 32'd1000) / 32'(HCDF_BATT_DIV_X10));
        if (link.h2d_valid && link.h2d_ready) begin
            next_s.tx_valid = 1'b0;
        end
        if (s.wait_cnt != 16'h0) begin
            next_s.wait_cnt = s.wait_cnt - 16'h1;
        end
        // ========================================
        // reply collection
        if (link.d2h_valid) begin
            next_s.rx = {s.rx[15:0], link.d2h_data};
            next_s.rx_idx = (s.rx_idx == 2'h2) ? 2'h0 : s.rx_idx + 2'h1;
            next_s.rx_done = (s.rx_idx == 2'h2);
        end
        // ========================================
        // register access
        if (wr) begin
            if (paddr == HCDF_A_TX) begin
                // busy or inside the settle wait: refuse with an error
                if (s.tx_valid || s.wait_cnt != 16'h0) begin
                    next_s.pslverr = 1'b1;
                end else begin
                    next_s.tx = pwdata[7:0];
                    next_s.tx_valid = 1'b1;
                    if (pwdata[8]) begin
                        next_s.wait_cnt = 16'(SW_WAIT_CYC);
                    end
                end
            end else if (paddr == HCDF_A_CTRL) begin
                // a reply byte landing in the same cycle wins over the clear
                if (pwdata[0] && !link.d2h_valid) begin
                    next_s.rx_done = 1'b0;
                    next_s.rx_idx = 2'h0;
                end
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        if (rd) begin
            if (paddr == HCDF_A_CTRL) begin
                next_s.prdata = 32'h0;
            end else if (paddr == HCDF_A_TX) begin
                next_s.prdata = {24'h0, s.tx};
            end else if (paddr == HCDF_A_STAT) begin
                next_s.prdata = {29'h0, s.wait_cnt != 16'h0, s.rx_done, s.tx_valid};
            end else if (paddr == HCDF_A_RX) begin
                next_s.prdata = {8'h0, s.rx};
            end else if (paddr == HCDF_A_CONV) begin
                next_s.prdata = {5'h0, batt_cv, rssi_r, rssi_l};
            end else begin
                next_s.prdata = 32'h0;
                next_s.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign link.h2d_data = s.tx;
    assign link.h2d_valid = s.tx_valid;
endmodule

// *** hcdf_link_chk.sv ***
/*
 checker for the byte link between host end and device end, plus the device
 outputs that answer host bytes.
 assumes one pclk and presetn for both ends; instantiated beside the interface.
*/
`timescale 1ns/10ps
module hcdf_link_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] h2d_data,
    input wire logic h2d_valid,
    input wire logic h2d_ready,
    input wire logic d2h_valid,
    input wire logic [2:0] channel,
    input wire logic channel_strobe,
    input wire logic diag_request,
    input wire logic frame_error
);
    import hcdf_pkg::*;
    // ==========================================
    // link properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence reply_s;
        d2h_valid [*3] ##1 !d2h_valid;
    endsequence
    sequence ch_byte_s;
        $past(h2d_valid) && $past(h2d_data) >= HCDF_CH_MIN && $past(h2d_data) <= HCDF_CH_MAX;
    endsequence
    ready_high_a: assert property (h2d_ready) else $error("device not ready");
    one_beat_a: assert property (h2d_valid |=> !h2d_valid) else $error("valid too long");
    reply_len_a: assert property ($rose(d2h_valid) |-> reply_s) else $error("reply length");
    strobe_cause_a: assert property (channel_strobe |-> ch_byte_s) else $error("bad strobe");
    strobe_val_a: assert property (channel_strobe |-> {5'h0, channel} == $past(h2d_data))
        else $error("channel value");
    chan_hold_a: assert property (!channel_strobe |-> $stable(channel)) else $error("drift");
    chan_range_a: assert property (channel >= 3'h1 && channel <= 3'h6) else $error("range");
    diag_cause_a: assert property (diag_request |-> $past(h2d_valid) && $past(h2d_data) != 8'h00)
        else $error("diag payload");
    err_cause_a: assert property (frame_error |-> $past(h2d_valid)) else $error("stray error");
endmodule

// *** host_channel_and_diag_frames_tb.sv ***
/*
 testbench: host end and device end joined by the link; software drives apb.
 assumes the host wait count is shortened to 20 cycles.
*/
`timescale 1ns/10ps
module host_channel_and_diag_frames_tb;
    import hcdf_pkg::*;
    // ==========================================
    // signals and instances
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic addr_en = 1, afa = 0, sp25 = 0, rv = 0, chs, dreq, ferr;
    logic [7:0] scode = 8'h5a, batt = 8'h00, rrs = 8'h00, lrs = 8'h00, dtgt, dpay;
    logic [2:0] channel;
    int miscompares = 0, num_checks = 0, cyc = 0, ndiag = 0, nerr = 0;
    hcdf_if link ();
    hcdf_host #(.SW_WAIT_CYC(20)) hcdf_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    hcdf_device hcdf_device_i (.pclk(pclk), .presetn(presetn), .link(link),
        .host_supplied_addressing(addr_en), .adaptive_freq_agility(afa), .spacing_25k(sp25),
        .system_code(scode), .remote_valid(rv), .supply_level_reading(batt),
        .remote_rssi(rrs), .local_rssi(lrs), .channel(channel), .channel_strobe(chs),
        .diag_request(dreq), .diag_target(dtgt), .diag_payload(dpay), .frame_error(ferr));
    hcdf_link_chk hcdf_link_chk_i (.pclk(pclk), .presetn(presetn), .h2d_data(link.h2d_data),
        .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready), .d2h_valid(link.d2h_valid),
        .channel(channel), .channel_strobe(chs), .diag_request(dreq), .frame_error(ferr));
    always #50 pclk = ~pclk;
    // ==========================================
    // shared tasks
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        ndiag += int'(dreq === 1'b1);
        nerr += int'(ferr === 1'b1);
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits out tx pending and the post switch wait
    task automatic idle();
        do apb(1'b0, HCDF_A_STAT, 32'h0); while (r[2:0] !== 3'h0);
    endtask
    task automatic send(input logic [7:0] b, input logic sw);
        idle();
        apb(1'b1, HCDF_A_TX, {23'h0, sw, b});
        cmp(e, 32'h0);
    endtask
    task automatic sw_frame(input logic [7:0] kind, input logic [7:0] ch, input logic [2:0] ex);
        send(HCDF_SW_LEAD, 1'b0);
        send(kind, 1'b0);
        send(ch, 1'b1);
        idle();
        cmp(channel, ex);
    endtask
    task automatic diag(input logic [7:0] flag, input int cnt, input logic [7:0] pay);
        send(scode, 1'b0);
        send(flag, 1'b0);
        send(8'(cnt), 1'b0);
        for (int i = 1; i <= cnt; i++) begin
            send(8'(i + 64), 1'b0);
        end
        send(pay, 1'b0);
        idle();
    endtask
    // ==========================================
    // scenarios
    task automatic t_switch();
        cmp(channel, 32'h1);
        send(HCDF_SW_LEAD, 1'b0);
        send(HCDF_SW_ADDR, 1'b0);
        send(8'h03, 1'b1);
        apb(1'b1, HCDF_A_TX, 32'h0);
        cmp(e, 32'h1);
        idle();
        cmp(channel, 32'h3);
        sw_frame(HCDF_SW_BCAST, 8'h06, 3'h6);
        sw_frame(HCDF_SW_ADDR, 8'h07, 3'h6);
        sw_frame(HCDF_SW_ADDR, 8'h00, 3'h6);
        sp25 <= 1'b1;
        sw_frame(HCDF_SW_ADDR, 8'h04, 3'h6);
        sw_frame(HCDF_SW_ADDR, 8'h03, 3'h3);
        afa <= 1'b1;
        sw_frame(HCDF_SW_ADDR, 8'h01, 3'h3);
        afa <= 1'b0;
        addr_en <= 1'b0;
        sw_frame(HCDF_SW_BCAST, 8'h02, 3'h3);
        addr_en <= 1'b1;
        sp25 <= 1'b0;
        $display("test t_switch done");
    endtask
    task automatic t_diag();
        int n0;
        diag(HCDF_DIAG_FLAG, 9, 8'hff);
        cmp(ndiag, 32'h1);
        cmp({dtgt, dpay}, 32'h49ff);
        n0 = nerr;
        diag(HCDF_DIAG_FLAG, 10, 8'h01);
        cmp(nerr - n0, 32'h1);
        n0 = nerr;
        diag(8'h09, 2, 8'h01);
        cmp(nerr - n0, 32'h1);
        n0 = nerr;
        diag(HCDF_DIAG_FLAG, 1, 8'h00);
        cmp(nerr - n0, 32'h1);
        cmp(ndiag, 32'h1);
        addr_en <= 1'b0;
        diag(HCDF_DIAG_FLAG, 1, 8'h01);
        cmp(ndiag, 32'h1);
        addr_en <= 1'b1;
        $display("test t_diag done");
    endtask
    task automatic t_reply();
        batt <= 8'h47;
        rrs <= 8'he0;
        lrs <= 8'h70;
        rv <= 1'b1;
        @(posedge pclk);
        rv <= 1'b0;
        do apb(1'b0, HCDF_A_STAT, 32'h0); while (r[1] !== 1'b1);
        apb(1'b0, HCDF_A_RX, 32'h0);
        cmp(r[23:0], 32'h47e070);
        apb(1'b0, HCDF_A_CONV, 32'h0);
        cmp(r[26:16], 32'd336);
        cmp(r[15:0], {16'h0, 8'd18, 8'd74});
        apb(1'b1, HCDF_A_CTRL, 32'h1);
        apb(1'b0, HCDF_A_STAT, 32'h0);
        cmp(r[1], 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        cmp(e, 32'h1);
        cmp(r, 32'h0);
        $display("test t_reply done");
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_switch();
        t_diag();
        t_reply();
        wrap_up();
    end
endmodule
